// File: hw/fcp_host.sv
// Host end of the framed serial command link, ordered over APB.
// Assumes the serial_byte_port leaf from the target file is compiled first.
`timescale 1ns/1ps
module fcp_host #(
   parameter int RETRIES = 2,
   parameter int TO_BYTE_TIMES = fcp_pkg::TO_BYTES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   fcp_link_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import fcp_pkg::*;
   host_state_e st_q;
   logic [15:0] div_q;
   logic [7:0] len_q, k_q, sum_q, rx_n_q, exp_q, rxi_q, rsum_q, tries_q;
   logic busy_q, done_q, tmo_q, chk_q;
   logic [24:0] to_q;
   logic [7:0] txb_q [0:MAX_PAYLOAD-1];
   logic [7:0] rxb_q [0:255];
   logic tx_rdy, rx_v;
   logic [7:0] rx_d;

   // Bus decode; every access takes one wait state.
   wire logic setup_w = psel && penable && !pready;
   wire logic wr_w = psel && penable && pready && pwrite;
   wire logic hit_w = (paddr == A_CTRL) || (paddr == A_STAT) || (paddr == A_TXB) ||
      (paddr == A_RXB) || (paddr == A_DIV);
   wire logic [31:0] rd_w = (paddr == A_CTRL) ? {16'h0000, len_q, 7'h00, busy_q} :
      (paddr == A_STAT) ? {8'h00, tries_q, rx_n_q, 4'h0, chk_q, tmo_q, done_q, busy_q} :
      (paddr == A_RXB) ? {24'h000000, rxb_q[rxi_q]} :
      (paddr == A_DIV) ? {16'h0000, div_q} : 32'h0000_0000;
   wire logic start_w = wr_w && paddr == A_CTRL && pwdata[0] && !busy_q &&
      pwdata[15:8] <= MAX_PAYLOAD;

   // Outgoing packet bytes and reply tracking.
   wire logic [7:0] last_k_w = 8'(len_q + 8'h02);
   wire logic [7:0] tx_b_w = (k_q == 8'h00) ? HDR : (k_q == 8'h01) ? 8'(len_q + 8'h03) :
      (k_q == last_k_w) ? sum_q : txb_q[8'(k_q - 8'h02)];
   wire logic tx_v_w = (st_q == H_SEND);
   wire logic fin_w = (rx_n_q == 8'h00 && rx_d != HDR) ||
      (rx_n_q >= 8'h02 && 8'(rx_n_q + 8'h01) == exp_q);
   wire logic [24:0] to_lim_w = 25'(TO_BYTE_TIMES * CHAR_BITS) * {9'h000, div_q};

   serial_byte_port u_port (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .div(div_q),
      .rxd(link.d2h_txd),
      .tx_valid(tx_v_w),
      .tx_data(tx_b_w),
      .tx_ready(tx_rdy),
      .txd(link.h2d_txd),
      .rx_valid(rx_v),
      .rx_data(rx_d)
   );

   // Payload and reply buffers.
   always_ff @(posedge pclk)
   begin
      if (clk_en && wr_w && paddr == A_TXB && !busy_q && pwdata[15:8] < MAX_PAYLOAD)
         txb_q[pwdata[15:8]] <= pwdata[7:0];
      if (clk_en && st_q == H_WAIT && rx_v)
         rxb_q[rx_n_q] <= rx_d;
   end

   // APB answer registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         pready <= setup_w;
         pslverr <= setup_w && !hit_w;
         if (setup_w)
            prdata <= rd_w;
      end
   end

   // Packet sender, reply collector, timeout and resend.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= H_IDLE;
         div_q <= 16'(DEF_DIV);
         {len_q, k_q, sum_q, rx_n_q, exp_q, rxi_q, rsum_q, tries_q} <= 64'h0;
         {busy_q, done_q, tmo_q, chk_q} <= 4'h0;
         to_q <= 25'h0000000;
      end
      else if (clk_en)
      begin
         if (wr_w && paddr == A_DIV && !busy_q && pwdata[15:0] != 16'h0000)
            div_q <= pwdata[15:0];
         if (wr_w && paddr == A_RXB)
            rxi_q <= pwdata[7:0];
         case (st_q)
            H_IDLE:
               if (start_w)
               begin
                  len_q <= pwdata[15:8];
                  {busy_q, done_q, tmo_q, chk_q} <= 4'h8;
                  tries_q <= 8'h00;
                  k_q <= 8'h00;
                  sum_q <= 8'h00;
                  st_q <= H_SEND;
               end
            H_SEND:
               if (tx_rdy)
               begin
                  sum_q <= 8'(sum_q + tx_b_w);
                  k_q <= 8'(k_q + 8'h01);
                  if (k_q == last_k_w)
                  begin
                     rx_n_q <= 8'h00;
                     rsum_q <= 8'h00;
                     to_q <= 25'h0000000;
                     st_q <= H_WAIT;
                  end
               end
            H_WAIT:
               if (rx_v)
               begin
                  rx_n_q <= 8'(rx_n_q + 8'h01);
                  rsum_q <= 8'(rsum_q + rx_d);
                  to_q <= 25'h0000000;
                  if (rx_n_q == 8'h01)
                     exp_q <= rx_d;
                  if (fin_w)
                  begin
                     {busy_q, done_q} <= 2'b01;
                     chk_q <= (rx_n_q == 8'h00) || (rx_d == rsum_q);
                     st_q <= H_IDLE;
                  end
               end
               else if (to_q >= to_lim_w)
               begin
                  if (tries_q < RETRIES)
                  begin
                     tries_q <= 8'(tries_q + 8'h01);
                     k_q <= 8'h00;
                     sum_q <= 8'h00;
                     st_q <= H_SEND;
                  end
                  else
                  begin
                     {busy_q, done_q, tmo_q} <= 3'b011;
                     st_q <= H_IDLE;
                  end
               end
               else
                  to_q <= 25'(to_q + 25'h0000001);
            default:
               st_q <= H_IDLE;
         endcase
      end
   end
endmodule

// File: hw/fcp_target.sv
// Target end of the framed serial command link, with its byte serialiser.
// Assumes straps and address pins are asynchronous, configuration inputs are on pclk.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module serial_byte_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic [15:0] div,
   input wire logic rxd,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic txd,
   output logic rx_valid,
   output logic [7:0] rx_data
);
   import fcp_pkg::*;
   logic s1_q, s2_q, rbusy_q, tbusy_q;
   logic [15:0] rcnt_q, tcnt_q;
   logic [3:0] rbit_q, tbit_q;
   logic [7:0] rsh_q;
   logic [9:0] tsh_q;

   assign tx_ready = !tbusy_q;

   // Receiver: finds the start edge, samples each bit at its centre.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         rbusy_q <= 1'b0;
         rcnt_q <= 16'h0000;
         rbit_q <= 4'h0;
         rsh_q <= 8'h00;
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
      end
      else if (clk_en)
      begin
         s1_q <= rxd;
         s2_q <= s1_q;
         rx_valid <= 1'b0;
         if (!rbusy_q)
         begin
            rbusy_q <= !s2_q;
            rcnt_q <= {1'b0, div[15:1]};
            rbit_q <= 4'h0;
         end
         else if (rcnt_q != 16'h0000)
            rcnt_q <= 16'(rcnt_q - 16'h0001);
         else
         begin
            rcnt_q <= 16'(div - 16'h0001);
            rbit_q <= 4'(rbit_q + 4'h1);
            if (rbit_q == 4'h0)
               rbusy_q <= !s2_q; // A glitch that is high at mid start is dropped.
            else if (rbit_q < 4'h9)
               rsh_q <= {s2_q, rsh_q[7:1]};
            else
            begin
               rbusy_q <= 1'b0;
               rx_valid <= s2_q; // A missing stop bit discards the byte.
               rx_data <= rsh_q;
            end
         end
      end
   end

   // Transmitter: low start, eight bits LSB first, high stop.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         txd <= 1'b1;
         tbusy_q <= 1'b0;
         tcnt_q <= 16'h0000;
         tbit_q <= 4'h0;
         tsh_q <= 10'h3FF;
      end
      else if (clk_en)
      begin
         if (!tbusy_q)
         begin
            txd <= 1'b1;
            tbusy_q <= tx_valid;
            tsh_q <= {1'b1, tx_data, 1'b0};
            tcnt_q <= 16'h0000;
            tbit_q <= 4'h0;
         end
         else if (tcnt_q != 16'h0000)
            tcnt_q <= 16'(tcnt_q - 16'h0001);
         else
         begin
            txd <= tsh_q[0];
            tsh_q <= {1'b1, tsh_q[9:1]};
            tcnt_q <= 16'(div - 16'h0001);
            tbit_q <= 4'(tbit_q + 4'h1);
            tbusy_q <= (tbit_q != 4'hA);
         end
      end
   end
endmodule

module fcp_target (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   fcp_link_if.device link,
   input wire logic host_port_select_a,
   input wire logic host_port_select_b,
   input wire logic [1:0] addr_pins,
   input wire logic [fcp_pkg::CFG_W-1:0] node_address_setting,
   input wire logic [fcp_pkg::CFG_W-1:0] baud_setting,
   output logic shared_select_direction_pin,
   output fcp_pkg::port_mode_e port_mode,
   output logic selected
);
   import fcp_pkg::*;
   tgt_state_e st_q;
   logic [3:0] sy1_q, sy2_q;
   logic [1:0] init_q;
   logic [15:0] div_q, ptr_q, rd_a_q;
   logic [7:0] node_q, cnt_q, idx_q, sum_q, ex_q, wr_i_q, wr_n_q, rd_n_q, tx_i_q, tsum_q, rc_q;
   logic sel_q, was_sel_q, rdat_q;
   logic [24:0] gap_q;
   logic [7:0] pkt_q [0:255];
   logic [7:0] ram_q [0:RAM_BYTES-1];
   logic rx_v, tx_rdy;
   logic [7:0] rx_d;

   // Reset-time configuration from straps, node address and stored rate.
   wire logic pins_low_w = (sy2_q[3:2] == 2'b00);
   wire logic [7:0] dev_addr_w = pins_low_w ? 8'h00 :
      {2'b00, node_address_setting[NODE_HI:NODE_LO], sy2_q[3:2]};
   wire logic baud_ok_w = (baud_setting >= MIN_BAUD) && (baud_setting <= MAX_BAUD);
   wire logic [15:0] div_w = baud_ok_w ? 16'(CLK_HZ / baud_setting) : 16'(DEF_DIV);
   wire port_mode_e mode_w = !sy2_q[0] ? MODE_SPI : (!sy2_q[1] ? MODE_UART : MODE_I2C);

   // Command decode at the execution index.
   wire logic [7:0] c_w = pkt_q[ex_q];
   wire logic [7:0] p1_w = pkt_q[8'(ex_q + 8'h01)];
   wire logic [7:0] p2_w = pkt_q[8'(ex_q + 8'h02)];
   wire logic [7:0] last_w = 8'(cnt_q - 8'h01);
   wire logic [7:0] avail_w = 8'(last_w - ex_q - 8'h01);
   wire logic [7:0] lo_w = {4'h0, c_w[3:0]};
   wire logic lo0_w = (c_w[3:0] == 4'h0);
   wire logic [7:0] wr_n_w = lo0_w ? avail_w : lo_w;
   wire logic [7:0] rd_n_w = lo0_w ? p1_w : lo_w;
   wire logic cmd_ok_w = (c_w[7:4] == 4'hA && c_w[3:2] == 2'b00) || c_w[7:4] == 4'hC ||
      c_w[7:4] == 4'hD || c_w[7:4] == 4'hE;
   wire logic [7:0] plen_w = (c_w[7:4] == 4'hA) ? ((c_w[3:0] == 4'h3) ? 8'h02 : {7'h00, !lo0_w}) :
      (c_w[7:4] == 4'hC) ? {7'h00, c_w[3:0] == 4'hF} :
      (c_w[7:4] == 4'hD) ? wr_n_w : {7'h00, lo0_w};
   wire logic need_ok_w = (avail_w >= plen_w);
   wire logic reply_ok_w = sel_q | was_sel_q;
   wire tgt_state_e end_st_w = reply_ok_w ? T_REPLY : T_HDR;
   wire logic [24:0] gap_lim_w = 25'(TO_BYTES * CHAR_BITS) * {9'h000, div_q};
   wire logic in_frame_w = (st_q == T_CNT) || (st_q == T_BODY);

   // Reply byte selection: code, count, data, checksum.
   wire logic [7:0] tx_last_w = rdat_q ? 8'(rd_n_q + 8'h02) : 8'h00;
   wire logic [15:0] rd_addr_w = 16'(rd_a_q + {8'h00, tx_i_q} - 16'h0002);
   wire logic [7:0] ram_rd_w = (rd_addr_w < RAM_BYTES) ? ram_q[rd_addr_w[RAM_AW-1:0]] : 8'h00;
   wire logic [7:0] tx_b_w = (tx_i_q == 8'h00) ? rc_q : (tx_i_q == 8'h01) ?
      8'(rd_n_q + 8'h03) : (tx_i_q == tx_last_w) ? tsum_q : ram_rd_w;
   wire logic tx_v_w = (st_q == T_REPLY);

   serial_byte_port u_port (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .div(div_q),
      .rxd(link.h2d_txd),
      .tx_valid(tx_v_w),
      .tx_data(tx_b_w),
      .tx_ready(tx_rdy),
      .txd(link.d2h_txd),
      .rx_valid(rx_v),
      .rx_data(rx_d)
   );

   // Packet store and register RAM; neither needs a reset value.
   always_ff @(posedge pclk)
   begin
      if (clk_en && st_q == T_BODY && rx_v)
         pkt_q[idx_q] <= rx_d;
      if (clk_en && st_q == T_WR && wr_n_q != 8'h00 && ptr_q < RAM_BYTES)
         ram_q[ptr_q[RAM_AW-1:0]] <= pkt_q[wr_i_q];
   end

   // Main sequencer: configuration, framing, execution and reply.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= T_INIT;
         sy1_q <= 4'h0;
         sy2_q <= 4'h0;
         init_q <= 2'h0;
         div_q <= 16'(DEF_DIV);
         {ptr_q, rd_a_q} <= 32'h0000_0000;
         {node_q, cnt_q, idx_q, sum_q, ex_q, wr_i_q} <= 48'h0000_0000_0000;
         {wr_n_q, rd_n_q, tx_i_q, tsum_q} <= 32'h0000_0000;
         rc_q <= RC_ACK;
         {sel_q, was_sel_q, rdat_q} <= 3'h0;
         gap_q <= 25'h0000000;
         port_mode <= MODE_SPI;
         shared_select_direction_pin <= 1'b0;
         selected <= 1'b0;
      end
      else if (clk_en)
      begin
         sy1_q <= {addr_pins, host_port_select_b, host_port_select_a};
         sy2_q <= sy1_q;
         gap_q <= (rx_v || !in_frame_w) ? 25'h0000000 : 25'(gap_q + 25'h0000001);
         shared_select_direction_pin <= sel_q && port_mode == MODE_UART;
         selected <= sel_q && port_mode == MODE_UART;
         if (st_q != T_REPLY)
         begin
            tx_i_q <= 8'h00;
            tsum_q <= 8'h00;
         end
         case (st_q)
            T_INIT:
            begin
               init_q <= 2'(init_q + 2'h1);
               if (init_q == 2'h3)
               begin
                  port_mode <= mode_w;
                  node_q <= 8'(dev_addr_w + 8'h01);
                  sel_q <= pins_low_w;
                  div_q <= div_w;
                  st_q <= (mode_w == MODE_UART) ? T_HDR : T_OFF;
               end
            end
            T_OFF:
               st_q <= T_OFF;
            T_HDR:
               if (rx_v && rx_d == HDR)
               begin
                  sum_q <= rx_d;
                  st_q <= T_CNT;
               end
            T_CNT:
               if (rx_v)
               begin
                  cnt_q <= rx_d;
                  sum_q <= 8'(sum_q + rx_d);
                  idx_q <= 8'h02;
                  st_q <= (rx_d < MIN_CNT) ? T_HDR : T_BODY;
               end
            T_BODY:
               if (rx_v)
               begin
                  idx_q <= 8'(idx_q + 8'h01);
                  sum_q <= 8'(sum_q + rx_d);
                  if (idx_q == last_w)
                  begin
                     ex_q <= 8'h02;
                     was_sel_q <= sel_q;
                     rdat_q <= 1'b0;
                     rc_q <= (rx_d == sum_q) ? RC_ACK : RC_BADSUM;
                     st_q <= (rx_d == sum_q) ? T_EXEC : (sel_q ? T_REPLY : T_HDR);
                  end
               end
            T_EXEC:
               if (ex_q == last_w || (!sel_q && c_w[7:4] != 4'hC))
                  st_q <= end_st_w;
               else if (!cmd_ok_w || !need_ok_w)
               begin
                  rc_q <= !cmd_ok_w ? RC_NOIMP : RC_NACK;
                  rdat_q <= 1'b0;
                  st_q <= end_st_w;
               end
               else
               begin
                  ex_q <= 8'(ex_q + 8'h01 + plen_w);
                  case (c_w[7:4])
                     4'hA:
                        ptr_q <= lo0_w ? 16'h0000 : (c_w[3:0] == 4'h1) ? {ptr_q[15:8], p1_w} :
                           (c_w[3:0] == 4'h2) ? {p1_w, ptr_q[7:0]} : {p2_w, p1_w};
                     4'hC:
                        sel_q <= (c_w[3:0] == 4'hF) ? (p1_w == node_q) : (lo_w == node_q);
                     4'hD:
                     begin
                        wr_i_q <= 8'(ex_q + 8'h01);
                        wr_n_q <= wr_n_w;
                        st_q <= T_WR;
                     end
                     default:
                        if (rd_n_w > MAX_RD)
                        begin
                           rc_q <= RC_OVF;
                           rdat_q <= 1'b0;
                           st_q <= end_st_w;
                        end
                        else
                        begin
                           rd_a_q <= ptr_q;
                           rd_n_q <= rd_n_w;
                           rdat_q <= 1'b1;
                           rc_q <= RC_ACK_DATA;
                           ptr_q <= 16'(ptr_q + {8'h00, rd_n_w});
                        end
                  endcase
               end
            T_WR:
               if (wr_n_q == 8'h00)
                  st_q <= T_EXEC;
               else
               begin
                  ptr_q <= 16'(ptr_q + 16'h0001);
                  wr_i_q <= 8'(wr_i_q + 8'h01);
                  wr_n_q <= 8'(wr_n_q - 8'h01);
               end
            T_REPLY:
               if (tx_rdy)
               begin
                  tsum_q <= 8'(tsum_q + tx_b_w);
                  tx_i_q <= 8'(tx_i_q + 8'h01);
                  if (tx_i_q == tx_last_w)
                     st_q <= T_HDR;
               end
            default:
               st_q <= T_INIT;
         endcase
         if (in_frame_w && gap_q >= gap_lim_w)
            st_q <= T_HDR; // A stalled frame is dropped without reply.
      end
   end
endmodule

// File: inc/fcp_link_if.sv
// Full-duplex serial link between the command host and one target.
// Idle level of both lines is high.
`timescale 1ns/1ps
interface fcp_link_if;
   logic h2d_txd;
   logic d2h_txd;
   modport device (input h2d_txd, output d2h_txd);
   modport host (output h2d_txd, input d2h_txd);
endinterface

// File: inc/fcp_pkg.sv
// Shared constants and types for the framed serial command link.
// Assumes a 20 MHz pclk on both ends of the link.
package fcp_pkg;
   // Timing.
   localparam int CLK_HZ = 20_000_000;
   localparam int DEF_BAUD = 38400;
   localparam int MAX_BAUD = 115200;
   localparam int MIN_BAUD = CLK_HZ / 65535 + 1;
   localparam int DEF_DIV = CLK_HZ / DEF_BAUD;
   localparam int STRAP_HOLD_MS = 10;
   localparam int TO_BYTES = 50;
   localparam int CHAR_BITS = 10;
   // Memory and configuration.
   localparam int CFG_W = 24;
   localparam int RAM_BYTES = 768;
   localparam int RAM_AW = 10;
   localparam int NODE_LO = 2;
   localparam int NODE_HI = 5;
   localparam int MAX_PAYLOAD = 252;
   // Packet bytes and reply codes.
   localparam logic [7:0] HDR = 8'hAA;
   localparam logic [7:0] MIN_CNT = 8'h03;
   localparam logic [7:0] MAX_RD = 8'hFC;
   localparam logic [7:0] RC_ACK_DATA = 8'hAA;
   localparam logic [7:0] RC_ACK = 8'hAD;
   localparam logic [7:0] RC_NACK = 8'hB0;
   localparam logic [7:0] RC_NOIMP = 8'hBC;
   localparam logic [7:0] RC_BADSUM = 8'hBD;
   localparam logic [7:0] RC_OVF = 8'hBF;
   // Host register offsets.
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_TXB = 8'h08;
   localparam logic [7:0] A_RXB = 8'h0C;
   localparam logic [7:0] A_DIV = 8'h10;
   typedef enum logic [2:0] {MODE_SPI = 3'b001, MODE_UART = 3'b010, MODE_I2C = 3'b100} port_mode_e;
   typedef enum logic [7:0] {
      T_INIT = 8'h01, T_OFF = 8'h02, T_HDR = 8'h04, T_CNT = 8'h08,
      T_BODY = 8'h10, T_EXEC = 8'h20, T_WR = 8'h40, T_REPLY = 8'h80
   } tgt_state_e;
   typedef enum logic [2:0] {H_IDLE = 3'b001, H_SEND = 3'b010, H_WAIT = 3'b100} host_state_e;
endpackage

// File: tb/fcp_link_assertions.sv
// Checks on the serial link lines and the target's select outputs.
// Assumes one pclk domain and a bit period of DIV pclk cycles.
`timescale 1ns/1ps
module fcp_link_assertions #(
   parameter int DIV = 173
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic h2d_txd,
   input wire logic d2h_txd,
   input wire logic selected,
   input wire logic shared_select_direction_pin,
   input fcp_pkg::port_mode_e port_mode
);
   import fcp_pkg::*;
   logic dprev_q;
   logic [15:0] drun_q, hidle_q, unsel_q;
   // Saturating counts: since the reply line moved, host line idle, target deselected.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dprev_q <= 1'b1;
         drun_q <= 16'(DIV);
         hidle_q <= 16'(DIV);
         unsel_q <= 16'h0000;
      end
      else
      begin
         dprev_q <= d2h_txd;
         drun_q <= (d2h_txd != dprev_q) ? 16'h0000 : drun_q + 16'(drun_q != 16'hFFFF);
         hidle_q <= !h2d_txd ? 16'h0000 : hidle_q + 16'(hidle_q != 16'hFFFF);
         unsel_q <= selected ? 16'h0000 : unsel_q + 16'(unsel_q != 16'hFFFF);
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_idle_after_reset: assert property ($rose(presetn) |-> h2d_txd && d2h_txd)
      else $error("link line not idle high after reset");
   a_dir_follows_sel: assert property (shared_select_direction_pin == selected)
      else $error("direction pin differs from select");
   a_sel_uart_only: assert property (selected |-> port_mode == MODE_UART)
      else $error("selected outside serial mode");
   a_mode_one_hot: assert property ($onehot(port_mode))
      else $error("port mode not one hot");
   a_start_bit_low: assert property ($fell(d2h_txd) |=> (!d2h_txd) [*8])
      else $error("reply low bit too short");
   a_reply_bit_time: assert property ((d2h_txd != dprev_q) |-> drun_q >= 16'(DIV - 2))
      else $error("reply bit shorter than bit period");
   a_quiet_when_unsel: assert property ($fell(d2h_txd) |-> unsel_q < 16'(12 * DIV))
      else $error("reply while deselected");
   a_reply_after_frame: assert property ($fell(d2h_txd) |-> hidle_q >= 16'(DIV / 4))
      else $error("reply during host frame");
   // Main scenarios seen on the link.
   c_reply: cover property ($fell(d2h_txd) && selected);
   c_deselect: cover property ($fell(selected));
   c_unsel_frame: cover property (!selected && $fell(h2d_txd));
endmodule

// File: tb/framed_uart_command_target_tb.sv
// Bench: APB orders to the host end, which talks to the target end over the link.
// Assumes one pclk for both ends and the target strapped for the serial port.
`timescale 1ns/1ps
module framed_uart_command_target_tb;
   import fcp_pkg::*;
   typedef logic [7:0] bytes_t[$];
   localparam int DIV = 173;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [1:0] addr_pins = 2'b00;
   logic strap_a = 1'b1;
   logic strap_b = 1'b0;
   logic [CFG_W-1:0] node_address_setting = 24'h0;
   logic [CFG_W-1:0] baud_setting = 24'(MAX_BAUD);
   logic [31:0] prdata, rd;
   logic pready, pslverr, bus_err, selected, dir_pin;
   port_mode_e port_mode;
   int fail_count = 0;
   int total_checks = 0;
   fcp_link_if lnk();
   fcp_target u_fcp_target (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .link(lnk.device),
      .host_port_select_a(strap_a), .host_port_select_b(strap_b), .addr_pins(addr_pins),
      .node_address_setting(node_address_setting), .baud_setting(baud_setting),
      .shared_select_direction_pin(dir_pin), .port_mode(port_mode), .selected(selected));
   fcp_host #(.RETRIES(0), .TO_BYTE_TIMES(2)) u_fcp_host (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .link(lnk.host), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   fcp_link_assertions #(.DIV(DIV)) u_fcp_link_assertions (.pclk(pclk), .presetn(presetn),
      .h2d_txd(lnk.h2d_txd), .d2h_txd(lnk.d2h_txd), .selected(selected),
      .shared_select_direction_pin(dir_pin), .port_mode(port_mode));
   // Clock with a 50 ns period.
   always #25 pclk = ~pclk;
   // Counts one comparison and reports a mismatch.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // A wait that ran out counts as a mismatch and ends the run.
   task automatic give_up();
      fail_count++;
      end_of_test();
   endtask
   // One APB transfer, held until pready is sampled high, then released.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && ++n < 9);
      rd = prdata;
      bus_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
         give_up();
   endtask
   // Expected data reply: code, count, data, then the low byte of the sum.
   function automatic bytes_t dr(input bytes_t d);
      bytes_t q;
      logic [7:0] s;
      q = {RC_ACK_DATA, 8'(d.size() + 3), d};
      s = 8'h00;
      foreach (q[i])
         s += q[i];
      return {q, s};
   endfunction
   // Sends one payload, waits for the end and checks every reply byte.
   task automatic xfer(input bytes_t p, input bytes_t e, input logic tmo);
      int n;
      foreach (p[i])
         apb(1'b1, A_TXB, {16'h0, 8'(i), p[i]});
      apb(1'b1, A_CTRL, {16'h0, 8'(p.size()), 8'h01});
      n = 0;
      do
      begin
         apb(1'b0, A_STAT, 32'h0);
         n++;
      end
      while (rd[0] !== 1'b0 && n < 6000);
      if (rd[0] !== 1'b0)
         give_up();
      chk("timeout flag", 32'(tmo), 32'(rd[2]));
      chk("status flags", {28'h0, !tmo, tmo, 2'b10}, {28'h0, rd[3:0]});
      chk("reply length", 32'(e.size()), 32'(rd[15:8]));
      foreach (e[i])
      begin
         apb(1'b1, A_RXB, 32'(i));
         apb(1'b0, A_RXB, 32'h0);
         chk("reply byte", 32'(e[i]), rd);
      end
      $display("test of %0d payload bytes done", p.size());
   endtask
   // Resets both ends again with new straps, held steady well past configuration.
   task automatic restart(input logic a, input logic b, input logic [1:0] pins);
      presetn <= 1'b0;
      strap_a <= a;
      strap_b <= b;
      addr_pins <= pins;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      $display("reset with straps %b%b done", a, b);
   endtask
   // Main sequence.
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("port mode", 32'(MODE_UART), 32'(port_mode));
      chk("select and direction", 32'h3, {30'h0, selected, dir_pin});
      apb(1'b0, A_DIV, 32'h0);
      chk("bit period reset", 32'(DEF_DIV), rd);
      apb(1'b1, A_DIV, 32'(DIV));
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 32'h1, 32'(bus_err));
      xfer('{8'hA0, 8'hD2, 8'h11, 8'h22, 8'hD0, 8'h33, 8'h44}, '{RC_ACK}, 1'b0);
      xfer('{8'hA3, 8'h01, 8'h00, 8'hE0, 8'h02}, dr('{8'h22, 8'h33}), 1'b0);
      xfer('{8'hE1}, dr('{8'h44}), 1'b0);
      xfer('{8'hF0}, '{RC_NOIMP}, 1'b0);
      xfer('{8'hC0}, '{RC_ACK}, 1'b0);
      chk("deselected", 32'h0, 32'(selected));
      xfer('{8'hA0}, '{}, 1'b1);
      node_address_setting <= 24'hFFFFC4;
      restart(1'b0, 1'b1, 2'b01);
      chk("port mode spi", 32'(MODE_SPI), 32'(port_mode));
      restart(1'b1, 1'b1, 2'b01);
      chk("port mode i2c", 32'(MODE_I2C), 32'(port_mode));
      restart(1'b1, 1'b0, 2'b01);
      chk("port mode uart", 32'(MODE_UART), 32'(port_mode));
      chk("not selected", 32'h0, {31'h0, selected});
      apb(1'b1, A_DIV, 32'(DIV));
      xfer('{8'hC6, 8'hCF}, '{RC_NACK}, 1'b0);
      chk("selected by node id", 32'h1, {31'h0, selected});
      end_of_test();
   end
endmodule
